// File: inc/srw_pkg.sv
// Purpose: Shared constants and types for the suspend and ring wake logic.
// Assumes: Two sockets, one per configuration function.
// Notes: Offsets are configuration byte addresses.
`default_nettype none
package srw_pkg;
  localparam int unsigned SRW_SOCKETS = 2;
  localparam int unsigned SRW_MULTIFUNCTION_PINS_W = 7;
  localparam int unsigned SRW_DIV_W = 16;
  localparam logic [SRW_DIV_W-1:0] SRW_PSW_DIV_DEF = 16'h0010;
  localparam logic [15:0] SRW_VENDOR_ID = 16'h1234;
  localparam logic [15:0] SRW_DEVICE_ID = 16'h5678;
  localparam logic [7:0] SRW_ADDR_ID = 8'h00;
  localparam logic [7:0] SRW_ADDR_HDR = 8'h0c;
  localparam logic [7:0] SRW_ADDR_SYS_CTRL = 8'h80;
  localparam logic [7:0] SRW_ADDR_CARD_DW = 8'h90;
  localparam logic [7:0] SRW_ADDR_CARD_CTRL = 8'h91;
  localparam logic [31:0] SRW_HDR_MULTI = 32'h0082_0000;
  localparam logic [31:0] SRW_SYS_CTRL_RST = 32'h0000_0000;
  localparam logic [7:0] SRW_CARD_CTRL_RST = 8'h00;
  localparam logic [7:0] SRW_CARD_GLB_MASK = 8'hc7;
  localparam int unsigned SRW_SYS_PME_SEL_BIT = 0;
  localparam int unsigned SRW_CC_RING_EN_BIT = 7;
  localparam int unsigned SRW_CC_STATUS_CHANGE_TO_RING_ENABLE_BIT = 5;
  localparam int unsigned SRW_CC_CSC_PEND_BIT = 3;
  localparam int unsigned SRW_CC_LANE = 1;
  localparam logic [0:0] SRW_FUNC0 = 1'h0;

  typedef enum logic [0:0] {
    SRW_RUN,
    SRW_SUSP
  } srw_mode_type;

  typedef struct packed {
    logic suspend;
    logic host_bus_reset_in;
    logic global_reset_in;
    logic [SRW_SOCKETS-1:0] ring_in;
    logic [SRW_SOCKETS-1:0] cstschg;
    logic [SRW_SOCKETS-1:0] card_status_change;
    logic [SRW_SOCKETS-1:0] powered;
    logic [SRW_SOCKETS-1:0] is_16bit;
  } srw_pins_type;

  typedef struct packed {
    logic valid;
    logic we;
    logic [0:0] func;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } srw_cfg_req_type;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } srw_cfg_rsp_type;
endpackage
`default_nettype wire

// File: hw/srw_pin_sync.sv
// Purpose: Three-stage synchroniser bank for pin inputs.
// Assumes: Inputs are asynchronous to core_clk_i.
// Notes: Output changes only when stages two and three agree.
`default_nettype none
module srw_pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] value_o
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] val;
  } srw_sync_state_type;

  srw_sync_state_type st_q;
  srw_sync_state_type st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = pin_i;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.val[i] = st_q.s3[i];
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign value_o = st_q.val;
endmodule
`default_nettype wire

// File: hw/srw_suspend_ring.sv
// Purpose: Suspend gating and ring wake signalling for a two-socket bridge.
// Assumes: core_clk_i is the free-running oscillator clock; pins pass the synchroniser.
// Notes: Function
// Function
// [RULE1] Suspend blocks host bus reset and global reset from registers.
// [RULE2] Suspend stops the internal bus clock.
// [RULE3] Power switch interface ticks from the oscillator, never the bus clock.
// [RULE4] Status change interrupts and ring wake reach host without bus clock.
// [RULE5] Serial interrupt runs on bus clock only; delivery waits for restart.
// [RULE6] Host arbiter must not park the bus here when suspend asserts.
// [RULE7] Suspend floats the bus request output.
// [RULE8] GPIO, multifunction pins and ring wake stay active unless disabled.
// [RULE9] Powered 16-bit card ring may drive ring wake.
// [RULE10] Unpowered CardBus status change pin is a wake event for ring wake.
// [RULE11] Card status change events may drive ring wake.
// [RULE12] Powered CardBus status pin is a status change; separate enables.
// [RULE13] Ring wake and power event share one pin; ring wake after reset.
// [RULE14] Software selects power event via system control bit 0, clears bit 7.
// [RULE15] Per-socket card control bit routes status changes to ring wake.
// [RULE16] Per-socket ring pass enable masks card ring, only for powered 16-bit.
// [RULE17] CardBus wake gated by the same status change mask bit.
// [RULE18] Each function has a 256-byte header; global bits via function 0.
// [RULE19] Device appears multifunction, socket functions 0 and 1.
// [RULE20] Context bits cleared by global reset only when power event enabled; code clears them on every global reset outside suspend.
// [RULE21] Ring wake is OR of all enabled unmasked sources of both sockets.
`default_nettype none
module srw_suspend_ring
  import srw_pkg::*;
#(
  parameter logic [SRW_DIV_W-1:0] PSW_DIV = SRW_PSW_DIV_DEF,
  parameter logic [15:0] VENDOR_ID = SRW_VENDOR_ID,
  parameter logic [15:0] DEVICE_ID = SRW_DEVICE_ID
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic suspend_i,
  input wire logic host_bus_reset_in_i,
  input wire logic global_reset_in_i,
  input wire logic [SRW_SOCKETS-1:0] ring_in_i,
  input wire logic [SRW_SOCKETS-1:0] cstschg_i,
  input wire logic [SRW_SOCKETS-1:0] card_status_change_i,
  input wire logic [SRW_SOCKETS-1:0] card_powered_i,
  input wire logic [SRW_SOCKETS-1:0] card_is_16bit_i,
  input wire logic [SRW_SOCKETS-1:0] card_ring_pass_enable_i,
  input wire logic [SRW_SOCKETS-1:0] status_change_mask_i,
  input wire logic pme_enable_i,
  input wire logic pme_event_i,
  input wire logic bus_req_int_i,
  input wire logic [SRW_MULTIFUNCTION_PINS_W-1:0] multifunction_value_i,
  input wire logic [SRW_MULTIFUNCTION_PINS_W-1:0] multifunction_enable_i,
  input wire srw_cfg_req_type cfg_req_i,
  output srw_cfg_rsp_type cfg_rsp_o,
  output logic pci_clk_en_o,
  output logic bus_req_o,
  output logic bus_req_oe_n_o,
  output logic psw_tick_o,
  output logic [SRW_SOCKETS-1:0] csc_irq_o,
  output logic [SRW_SOCKETS-1:0] serirq_csc_req_o,
  output logic wake_pin_o,
  output logic [SRW_MULTIFUNCTION_PINS_W-1:0] multifunction_pins_o
);
  typedef struct packed {
    srw_mode_type mode;
    logic [31:0] sys_ctrl;
    logic [7:0] card_glb;
    logic [SRW_SOCKETS-1:0] status_change_to_ring_enable;
    logic [SRW_SOCKETS-1:0] csc_pend;
    logic [SRW_SOCKETS-1:0] evt_prev;
    logic [SRW_SOCKETS-1:0] srq_pend;
    logic [SRW_DIV_W-1:0] div_cnt;
    logic psw_tick;
    logic pci_clk_en;
    logic req;
    logic req_oe_n;
    logic [SRW_SOCKETS-1:0] csc_irq;
    logic [SRW_SOCKETS-1:0] serirq;
    logic wake_pin;
    logic [SRW_MULTIFUNCTION_PINS_W-1:0] multifunction_pins;
    srw_cfg_rsp_type rsp;
  } srw_state_type;

  srw_state_type st_q;
  srw_state_type st_d;
  srw_pins_type pins_raw;
  srw_pins_type pins;
  logic [$bits(srw_pins_type)-1:0] pins_sync;

  always_comb begin
    pins_raw.suspend = suspend_i;
    pins_raw.host_bus_reset_in = host_bus_reset_in_i;
    pins_raw.global_reset_in = global_reset_in_i;
    pins_raw.ring_in = ring_in_i;
    pins_raw.cstschg = cstschg_i;
    pins_raw.card_status_change = card_status_change_i;
    pins_raw.powered = card_powered_i;
    pins_raw.is_16bit = card_is_16bit_i;
  end

  srw_pin_sync #(
    .WIDTH($bits(srw_pins_type))
  ) u_pin_sync (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(pins_raw),
    .value_o(pins_sync)
  );

  assign pins = srw_pins_type'(pins_sync);

  logic susp;
  logic host_bus_reset_in_eff;
  logic global_reset_in_eff;
  logic ctx_clr;
  logic ring_en;
  logic [SRW_SOCKETS-1:0] ring_src;
  logic [SRW_SOCKETS-1:0] wake_src;
  logic [SRW_SOCKETS-1:0] csc_evt;
  logic [SRW_SOCKETS-1:0] csc_rise;
  logic [SRW_SOCKETS-1:0] csc_ring;
  logic ring_out;
  logic acc;
  logic wr;
  logic [7:0] cc_wbyte;
  logic [7:0] cc_rbyte;
  logic [7:0] cc_wmask;

  always_comb begin
    susp = pins.suspend;
    host_bus_reset_in_eff = pins.host_bus_reset_in && !susp; // see [RULE1]
    global_reset_in_eff = pins.global_reset_in && !susp; // see [RULE1]
    ctx_clr = global_reset_in_eff || (host_bus_reset_in_eff && !pme_enable_i); // see [RULE20]
    ring_en = st_q.card_glb[SRW_CC_RING_EN_BIT];
    for (int s = 0; s < SRW_SOCKETS; s++) begin
      ring_src[s] = pins.ring_in[s] && pins.powered[s] && pins.is_16bit[s]
        && card_ring_pass_enable_i[s]; // see [RULE9] see [RULE16]
      wake_src[s] = pins.cstschg[s] && !pins.powered[s] && !pins.is_16bit[s]
        && status_change_mask_i[s]; // see [RULE10] see [RULE17]
      csc_evt[s] = pins.card_status_change[s] || (pins.cstschg[s] && pins.powered[s]
        && !pins.is_16bit[s] && status_change_mask_i[s]); // see [RULE12]
      csc_ring[s] = st_q.csc_pend[s] && st_q.status_change_to_ring_enable[s]; // see [RULE11] see [RULE15]
    end
    csc_rise = csc_evt & ~st_q.evt_prev;
    ring_out = ring_en && |(ring_src | wake_src | csc_ring); // see [RULE21]
  end

  always_comb begin
    acc = cfg_req_i.valid && (st_q.mode == SRW_RUN); // see [RULE2]
    wr = acc && cfg_req_i.we;
    cc_wbyte = cfg_req_i.wdata[SRW_CC_LANE*8 +: 8];
    cc_rbyte = st_q.card_glb & SRW_CARD_GLB_MASK;
    cc_rbyte[SRW_CC_STATUS_CHANGE_TO_RING_ENABLE_BIT] = st_q.status_change_to_ring_enable[cfg_req_i.func];
    cc_rbyte[SRW_CC_CSC_PEND_BIT] = st_q.csc_pend[cfg_req_i.func];
    if (cfg_req_i.func == SRW_FUNC0) begin
      cc_wmask = SRW_CARD_GLB_MASK; // see [RULE18]
    end else begin
      cc_wmask = 8'h00;
    end
  end

  always_comb begin
    st_d = st_q;
    st_d.rsp.ack = 1'b0;
    st_d.evt_prev = csc_evt;
    // Mode follows the synchronised suspend level
    case (st_q.mode)
      SRW_RUN: begin
        if (susp) begin
          st_d.mode = SRW_SUSP;
        end
      end
      SRW_SUSP: begin
        if (!susp) begin
          st_d.mode = SRW_RUN;
        end
      end
      default: begin
        st_d.mode = SRW_RUN;
      end
    endcase
    st_d.pci_clk_en = !susp; // see [RULE2]
    st_d.req = bus_req_int_i && !susp;
    st_d.req_oe_n = susp; // see [RULE7] see [RULE6]
    // Power switch tick from the free-running clock
    st_d.psw_tick = 1'b0;
    if (st_q.div_cnt >= PSW_DIV - 1'b1) begin
      st_d.div_cnt = '0;
      st_d.psw_tick = 1'b1; // see [RULE3]
    end else begin
      st_d.div_cnt = st_q.div_cnt + 1'b1;
    end
    // Software clears pending status by writing one, event set wins
    if (wr && cfg_req_i.addr == SRW_ADDR_CARD_DW && cfg_req_i.be[SRW_CC_LANE]
        && cc_wbyte[SRW_CC_CSC_PEND_BIT]) begin
      st_d.csc_pend[cfg_req_i.func] = 1'b0;
    end
    st_d.csc_pend = st_d.csc_pend | csc_rise;
    // Serial interrupt request held until the bus clock runs
    st_d.srq_pend = st_q.srq_pend | csc_rise;
    st_d.serirq = '0;
    if (st_q.mode == SRW_RUN && !susp) begin
      st_d.serirq = st_q.srq_pend; // see [RULE5]
      st_d.srq_pend = csc_rise;
    end
    st_d.csc_irq = st_d.csc_pend; // see [RULE4]
    if (st_q.sys_ctrl[SRW_SYS_PME_SEL_BIT] && !ring_en) begin
      st_d.wake_pin = pme_event_i && pme_enable_i; // see [RULE14]
    end else begin
      st_d.wake_pin = ring_out; // see [RULE13] see [RULE4]
    end
    st_d.multifunction_pins = multifunction_value_i & multifunction_enable_i; // see [RULE8]
    // Configuration access
    if (acc) begin
      st_d.rsp.ack = 1'b1;
      st_d.rsp.rdata = '0;
      if (cfg_req_i.addr == SRW_ADDR_ID) begin
        st_d.rsp.rdata = {DEVICE_ID, VENDOR_ID};
      end else if (cfg_req_i.addr == SRW_ADDR_HDR) begin
        st_d.rsp.rdata = SRW_HDR_MULTI; // see [RULE19]
      end else if (cfg_req_i.addr == SRW_ADDR_SYS_CTRL) begin
        st_d.rsp.rdata = st_q.sys_ctrl;
        if (cfg_req_i.we && cfg_req_i.func == SRW_FUNC0) begin
          for (int b = 0; b < 4; b++) begin
            if (cfg_req_i.be[b]) begin
              st_d.sys_ctrl[b*8 +: 8] = cfg_req_i.wdata[b*8 +: 8]; // see [RULE18]
            end
          end
        end
      end else if (cfg_req_i.addr == SRW_ADDR_CARD_DW) begin
        st_d.rsp.rdata[SRW_CC_LANE*8 +: 8] = cc_rbyte;
        if (cfg_req_i.we && cfg_req_i.be[SRW_CC_LANE]) begin
          st_d.card_glb = (st_q.card_glb & ~cc_wmask) | (cc_wbyte & cc_wmask);
          st_d.status_change_to_ring_enable[cfg_req_i.func] = cc_wbyte[SRW_CC_STATUS_CHANGE_TO_RING_ENABLE_BIT]; // see [RULE15]
        end
      end
    end
    // Gated resets
    if (host_bus_reset_in_eff || global_reset_in_eff) begin
      st_d.status_change_to_ring_enable = '0;
      st_d.rsp.ack = 1'b0;
    end
    if (global_reset_in_eff) begin
      st_d.sys_ctrl = SRW_SYS_CTRL_RST;
      st_d.card_glb = SRW_CARD_CTRL_RST;
    end
    if (ctx_clr) begin
      st_d.csc_pend = '0; // see [RULE20]
      st_d.srq_pend = '0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st_q <= '0;
      st_q.mode <= SRW_RUN;
      st_q.sys_ctrl <= SRW_SYS_CTRL_RST;
      st_q.card_glb <= SRW_CARD_CTRL_RST;
      st_q.req_oe_n <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign cfg_rsp_o = st_q.rsp;
  assign pci_clk_en_o = st_q.pci_clk_en;
  assign bus_req_o = st_q.req;
  assign bus_req_oe_n_o = st_q.req_oe_n;
  assign psw_tick_o = st_q.psw_tick;
  assign csc_irq_o = st_q.csc_irq;
  assign serirq_csc_req_o = st_q.serirq;
  assign wake_pin_o = st_q.wake_pin;
  assign multifunction_pins_o = st_q.multifunction_pins;
endmodule
`default_nettype wire

// File: test/srw_suspend_ring_assertions.sv
// Purpose: Port-level checks for the suspend and ring wake block.
// Assumes: Pin inputs pass a synchroniser of a few cycles.
// Notes: Bound to every instance of the block.
`default_nettype none
module srw_suspend_ring_chk
  import srw_pkg::*;
#(
  parameter logic [SRW_DIV_W-1:0] PSW_DIV = SRW_PSW_DIV_DEF
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic suspend_i,
  input wire logic [SRW_SOCKETS-1:0] ring_in_i,
  input wire logic [SRW_SOCKETS-1:0] cstschg_i,
  input wire logic pme_event_i,
  input wire logic [SRW_MULTIFUNCTION_PINS_W-1:0] multifunction_value_i,
  input wire logic [SRW_MULTIFUNCTION_PINS_W-1:0] multifunction_enable_i,
  input wire srw_cfg_req_type cfg_req_i,
  input wire srw_cfg_rsp_type cfg_rsp_o,
  input wire logic pci_clk_en_o,
  input wire logic bus_req_oe_n_o,
  input wire logic psw_tick_o,
  input wire logic [SRW_SOCKETS-1:0] csc_irq_o,
  input wire logic [SRW_SOCKETS-1:0] serirq_csc_req_o,
  input wire logic wake_pin_o,
  input wire logic [SRW_MULTIFUNCTION_PINS_W-1:0] multifunction_pins_o
);
  logic [SRW_DIV_W-1:0] gap_q;
  logic seen_q;
  // Cycles since the last power switch tick
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || psw_tick_o) begin
      gap_q <= '0;
    end else begin
      gap_q <= gap_q + 1'b1;
    end
  end
  always_ff @(posedge core_clk_i) begin
    seen_q <= !sys_rst_i && (seen_q || psw_tick_o);
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_ack; cfg_rsp_o.ack |-> $past(cfg_req_i.valid); endproperty
  a_ack: assert property (p_ack) else $error("ack without request");
  property p_ack_susp; suspend_i [*6] |=> !cfg_rsp_o.ack; endproperty
  a_ack_susp: assert property (p_ack_susp) else $error("ack in suspend");
  property p_clk_lo; suspend_i [*6] |-> !pci_clk_en_o; endproperty
  a_clk_lo: assert property (p_clk_lo) else $error("bus clock runs in suspend");
  property p_clk_hi; !suspend_i [*8] |-> pci_clk_en_o; endproperty
  a_clk_hi: assert property (p_clk_hi) else $error("bus clock stopped");
  property p_float; suspend_i [*6] |-> bus_req_oe_n_o; endproperty
  a_float: assert property (p_float) else $error("request driven in suspend");
  property p_psw;
    seen_q |-> (psw_tick_o ? gap_q == PSW_DIV - 1'b1 : gap_q < PSW_DIV - 1'b1);
  endproperty
  a_psw: assert property (p_psw) else $error("tick spacing wrong");
  property p_quiet;
    (ring_in_i == '0 && cstschg_i == '0 && !pme_event_i && csc_irq_o == '0) [*8]
      |-> !wake_pin_o;
  endproperty
  a_quiet: assert property (p_quiet) else $error("wake without source");
  property p_serirq; suspend_i [*6] |-> serirq_csc_req_o == '0; endproperty
  a_serirq: assert property (p_serirq) else $error("serial request in suspend");
  property p_mf;
    1'b1 |=> multifunction_pins_o == $past(multifunction_value_i & multifunction_enable_i);
  endproperty
  a_mf: assert property (p_mf) else $error("multifunction pins wrong");
endmodule
bind srw_suspend_ring srw_suspend_ring_chk #(.PSW_DIV(PSW_DIV)) i_srw_suspend_ring_chk (
  .core_clk_i, .sys_rst_i, .suspend_i, .ring_in_i, .cstschg_i, .pme_event_i,
  .multifunction_value_i, .multifunction_enable_i, .cfg_req_i, .cfg_rsp_o, .pci_clk_en_o,
  .bus_req_oe_n_o, .psw_tick_o, .csc_irq_o, .serirq_csc_req_o, .wake_pin_o,
  .multifunction_pins_o);
`default_nettype wire

// File: test/srw_host_model.sv
// Purpose: Host side that raises and drops the suspend pin.
// Assumes: Requests come on the bench clock.
// Notes: Waits while the request line is driven high.
`default_nettype none
module srw_host_model
  import srw_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic sleep_req_i,
  input wire logic bus_req_i,
  input wire logic bus_req_oe_n_i,
  output logic suspend_o
);
  initial suspend_o = 1'b0;
  // Suspend only when not parked here
  always @(posedge core_clk_i) begin
    if (!sleep_req_i) begin
      suspend_o <= 1'b0;
    end else if (bus_req_oe_n_i || !bus_req_i) begin
      suspend_o <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: test/srw_suspend_ring_bench.sv
// Purpose: Register and pin scenarios for the suspend and ring wake block.
// Assumes: Four-cycle tick divider.
// Notes: Waits of eight cycles cover the pin synchroniser.
`default_nettype none
module srw_suspend_ring_bench
  import srw_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk_i, sys_rst_i, suspend_i, host_bus_reset_in_i, global_reset_in_i, sleep_q;
  logic pme_enable_i, pme_event_i, bus_req_int_i, pci_clk_en_o, bus_req_o, bus_req_oe_n_o;
  logic psw_tick_o, wake_pin_o;
  logic [1:0] ring_in_i, cstschg_i, card_status_change_i, card_powered_i, card_is_16bit_i;
  logic [1:0] card_ring_pass_enable_i, status_change_mask_i, csc_irq_o, serirq_csc_req_o;
  logic [6:0] multifunction_value_i, multifunction_enable_i, multifunction_pins_o;
  srw_cfg_req_type cfg_req_i;
  srw_cfg_rsp_type cfg_rsp_o;
  logic [31:0] rv;
  int n_fail, tests_run, cyc_n;
  srw_suspend_ring #(.PSW_DIV(16'h0004)) i_srw_suspend_ring (.core_clk_i, .sys_rst_i,
    .suspend_i, .host_bus_reset_in_i, .global_reset_in_i, .ring_in_i, .cstschg_i,
    .card_status_change_i, .card_powered_i, .card_is_16bit_i, .card_ring_pass_enable_i,
    .status_change_mask_i, .pme_enable_i, .pme_event_i, .bus_req_int_i,
    .multifunction_value_i, .multifunction_enable_i, .cfg_req_i, .cfg_rsp_o, .pci_clk_en_o,
    .bus_req_o, .bus_req_oe_n_o, .psw_tick_o, .csc_irq_o, .serirq_csc_req_o, .wake_pin_o,
    .multifunction_pins_o);
  srw_host_model i_srw_host_model (.core_clk_i, .sleep_req_i(sleep_q), .bus_req_i(bus_req_o),
    .bus_req_oe_n_i(bus_req_oe_n_o), .suspend_o(suspend_i));
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic acc(input logic w, f, input logic [7:0] a, input logic [3:0] b,
    input logic [31:0] d);
    cfg_req_i = '{1'b1, w, f, a, b, d};
    do @(posedge core_clk_i); while (cfg_rsp_o.ack !== 1'b1);
    rv = cfg_rsp_o.rdata;
    #1 cfg_req_i.valid = 1'b0;
    cyc(1);
  endtask
  task automatic rdc(input logic f, input logic [7:0] a, input logic [31:0] m, e);
    acc(1'b0, f, a, 4'hf, '0);
    chk(rv & m, e);
  endtask
  task wrap_up;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    cyc_n++;
    if (cyc_n == 4000) begin
      n_fail++;
      wrap_up();
    end
  end
  initial begin
    {host_bus_reset_in_i, global_reset_in_i, pme_enable_i, pme_event_i, sleep_q} = '0;
    {ring_in_i, cstschg_i, card_status_change_i, card_powered_i, card_is_16bit_i} = '0;
    {card_ring_pass_enable_i, status_change_mask_i} = '0;
    {multifunction_value_i, multifunction_enable_i} = {7'h55, 7'h0f};
    cfg_req_i = '0;
    bus_req_int_i = 1'b1;
    sys_rst_i = 1'b1;
    cyc(12);
    sys_rst_i = 1'b0;
    cyc(4);
    rdc(0, SRW_ADDR_SYS_CTRL, '1, SRW_SYS_CTRL_RST);
    rdc(0, SRW_ADDR_HDR, '1, SRW_HDR_MULTI);
    rdc(1, SRW_ADDR_HDR, '1, SRW_HDR_MULTI);
    rdc(1, SRW_ADDR_ID, '1, {SRW_DEVICE_ID, SRW_VENDOR_ID});
    rdc(0, 8'hfc, '1, 32'h0);
    chk(32'(bus_req_oe_n_o), 32'h0);
    chk(32'(bus_req_o), 32'h1);
    chk(32'(wake_pin_o), 32'h0);
    acc(1, 0, SRW_ADDR_CARD_DW, 4'h2, 32'h8000);
    {card_powered_i, card_is_16bit_i, card_ring_pass_enable_i, ring_in_i} = 8'h55;
    cyc(8);
    chk(32'(wake_pin_o), 32'h1);
    card_ring_pass_enable_i = 2'b00;
    cyc(8);
    chk(32'(wake_pin_o), 32'h0);
    {ring_in_i, cstschg_i, status_change_mask_i} = 6'b00_10_10;
    cyc(8);
    chk(32'(wake_pin_o), 32'h1);
    status_change_mask_i = 2'b00;
    cyc(8);
    chk(32'(wake_pin_o), 32'h0);
    {card_is_16bit_i, cstschg_i, status_change_mask_i} = 6'b00_01_01;
    cyc(8);
    chk(32'(csc_irq_o), 32'h1);
    chk(32'(wake_pin_o), 32'h0);
    cstschg_i = 2'b00;
    acc(1, 0, SRW_ADDR_CARD_DW, 4'h2, 32'ha000);
    chk(32'(wake_pin_o), 32'h1);
    acc(1, 0, SRW_ADDR_CARD_DW, 4'h2, 32'ha800);
    chk(32'(csc_irq_o), 32'h0);
    card_status_change_i = 2'b10;
    cyc(8);
    chk(32'(csc_irq_o), 32'h2);
    chk(32'(wake_pin_o), 32'h0);
    card_status_change_i = 2'b00;
    acc(1, 1, SRW_ADDR_CARD_DW, 4'h2, 32'h0800);
    chk(32'(csc_irq_o), 32'h0);
    rdc(0, SRW_ADDR_CARD_DW, 32'hff00, 32'ha000);
    acc(1, 0, SRW_ADDR_SYS_CTRL, 4'hf, 32'h1);
    acc(1, 0, SRW_ADDR_CARD_DW, 4'h2, 32'h0);
    acc(1, 1, SRW_ADDR_SYS_CTRL, 4'hf, 32'h0);
    rdc(0, SRW_ADDR_SYS_CTRL, '1, 32'h1);
    {pme_enable_i, pme_event_i} = 2'b11;
    cyc(8);
    chk(32'(wake_pin_o), 32'h1);
    {pme_event_i, bus_req_int_i, sleep_q} = 3'b001;
    cyc(12);
    chk(32'(pci_clk_en_o), 32'h0);
    chk(32'(bus_req_oe_n_o), 32'h1);
    {host_bus_reset_in_i, global_reset_in_i, card_status_change_i} = 4'b1101;
    multifunction_value_i = 7'h2a;
    cyc(8);
    {host_bus_reset_in_i, global_reset_in_i} = 2'b00;
    chk(32'(multifunction_pins_o), 32'h0a);
    chk(32'(csc_irq_o), 32'h1);
    {sleep_q, card_status_change_i} = 3'b000;
    cyc(12);
    chk(32'(pci_clk_en_o), 32'h1);
    rdc(0, SRW_ADDR_SYS_CTRL, '1, 32'h1);
    global_reset_in_i = 1'b1;
    cyc(8);
    global_reset_in_i = 1'b0;
    cyc(8);
    rdc(0, SRW_ADDR_SYS_CTRL, '1, 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
